// *** exec_defs.svh ***
/*
  register offsets, field positions, reset values and pointer
  placement for the bit, flag and transfer execution unit.
  assumes nothing; definitions only.
*/
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// --------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------
`define OFF_CMD    8'h00
`define OFF_ARG    8'h04
`define OFF_FLAGS  8'h08
`define OFF_SP     8'h0C
`define OFF_RIDX   8'h10
`define OFF_RDATA  8'h14
`define OFF_CTRL   8'h18
`define OFF_STAT   8'h1C

// --------------------------------------------------------------
// flag register bit positions
// --------------------------------------------------------------
`define FL_C 0
`define FL_Z 1
`define FL_N 2
`define FL_V 3
`define FL_S 4
`define FL_H 5
`define FL_T 6
`define FL_I 7

// --------------------------------------------------------------
// pointer pairs (low byte index), fixed registers, resets
// --------------------------------------------------------------
`define PTR_X      5'h1A
`define PTR_Y      5'h1C
`define PTR_Z      5'h1E
`define REG_R0     5'h00
`define FLAGS_RST  8'h00
`define SP_RST     16'h00FF
`define ARG_RST    16'h0000
`define CTRL_RST   2'h0
`define STAT_BUSY  0
`define STAT_SLEEP 1

`endif

// *** exec_pkg.sv ***
/*
  types shared by the execution unit and its flag/shift helper.
  assumes exec_defs.svh for numeric constants.
*/
`default_nettype none
package exec_pkg;

  // ------------------------------------------------------------
  // operations, states, carriers
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_RRC        = 5'h01,
    OP_SRA        = 5'h02,
    OP_B2T        = 5'h03,
    OP_T2B        = 5'h04,
    OP_FLAG       = 5'h05,
    OP_LD         = 5'h06,
    OP_LD_INC     = 5'h07,
    OP_LD_DEC     = 5'h08,
    OP_LDQ        = 5'h09,
    OP_ST         = 5'h0A,
    OP_ST_INC     = 5'h0B,
    OP_ST_DEC     = 5'h0C,
    OP_STQ        = 5'h0D,
    OP_LDA        = 5'h0E,
    OP_STA        = 5'h0F,
    OP_PMR_R0     = 5'h10,
    OP_PMR        = 5'h11,
    OP_PMR_INC    = 5'h12,
    OP_PUSH       = 5'h13,
    OP_POP        = 5'h14,
    OP_SLEEP      = 5'h15,
    OP_KICK       = 5'h16
  } op_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_EXEC = 5'b00010,
    ST_MEM  = 5'b00100,
    ST_PM1  = 5'b01000,
    ST_PM2  = 5'b10000
  } state_type;

  typedef struct packed {
    logic       flag_set;
    logic [2:0] bit_sel;
    logic [1:0] ptr_sel;
    logic [4:0] reg_idx;
    op_type     op;
  } cmd_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dmem_type;

endpackage
`default_nettype wire

// *** flag_shift_unit.sv ***
/*
  combinational shift, rotate, bit transfer and flag set/clear.
  assumes the caller registers results in the execute cycle.
*/
`timescale 1ns/1ns
`include "exec_defs.svh"
`default_nettype none

module flag_shift_unit (
  input  wire exec_pkg::op_type i_op,
  input  wire logic [7:0]       i_val,
  input  wire logic [7:0]       i_flags,
  input  wire logic [2:0]       i_sel,
  input  wire logic             i_set,
  output logic [7:0]            o_val,
  output logic [7:0]            o_flags
);
  import exec_pkg::*;

  logic [7:0] ins_val;
  logic [7:0] set_flags;

  // --------------------------------------------------------------
  // per-bit insert and flag select
  // --------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_bit
    assign ins_val[g]   = (i_sel == 3'(g)) ? i_flags[`FL_T] : i_val[g]; // RQ4
    assign set_flags[g] = (i_sel == 3'(g)) ? i_set : i_flags[g];       // RQ5
  end

  always_comb begin
    o_val   = i_val;
    o_flags = i_flags;
    case (i_op)
      OP_RRC: begin
        o_val            = {i_flags[`FL_C], i_val[7:1]}; // RQ1
        o_flags[`FL_C]   = i_val[0];                    // RQ1
      end
      OP_SRA: begin
        o_val            = {i_val[7], i_val[7:1]};      // RQ2
        o_flags[`FL_C]   = i_val[0];                    // RQ2
      end
      OP_B2T:  o_flags[`FL_T] = i_val[i_sel];           // RQ3
      OP_T2B:  o_val   = ins_val;                       // RQ4
      OP_FLAG: o_flags = set_flags;                     // RQ5
      default: o_val   = i_val;
    endcase
    // v follows n xor c after the shift
    if (i_op == OP_RRC || i_op == OP_SRA) begin
      o_flags[`FL_Z] = (o_val == 8'h00);                 // RQ1
      o_flags[`FL_N] = o_val[7];                         // RQ2
      o_flags[`FL_V] = o_val[7] ^ o_flags[`FL_C];        // RQ1
    end
  end

endmodule // flag_shift_unit
`default_nettype wire

// *** exec_unit.sv ***
/*
  execution unit for shifts, flag moves, data and program memory
  transfers, stack, sleep and watchdog kick, driven over apb.
  assumes a data sram with combinational read, a program memory
  with one-cycle registered read, and one 125 MHz clock.
*/
// Functional notes
// RQ1: rotate right through carry, flags, one cycle
// RQ2: arithmetic shift right keeps bit 7
// RQ3: copy register bit into transfer flag
// RQ4: transfer flag into register bit, no flags
// RQ5: set or clear exactly one flag
// RQ6: pointer read then increment, two cycles
// RQ7: decrement pointer then read, two cycles
// RQ8: read at pointer plus displacement, two cycles
// RQ9: pointer write then increment, two cycles
// RQ10: decrement pointer then write, two cycles
// RQ11: write at pointer plus displacement
// RQ12: direct address read, two cycles
// RQ13: direct address write, two cycles
// RQ14: program memory read via z, three cycles
// RQ15: push register, adjust stack pointer
// RQ16: pop into register, adjust stack pointer
// RQ17: sleep one cycle, enter configured mode
// RQ18: watchdog kick one cycle, flags unchanged
`timescale 1ns/1ns
`include "exec_defs.svh"
`default_nettype none

module exec_unit (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output exec_pkg::dmem_type     o_dmem,
  input  wire logic [7:0]        i_dmem_rdata,
  output logic [15:0]            o_pmem_addr,
  input  wire logic [7:0]        i_pmem_rdata,
  output logic                   o_sleep,
  output logic [1:0]             o_sleep_mode,
  output logic                   o_wdt_kick
);
  import exec_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [7:0]  regs [0:31];
  cmd_type     cmd;
  state_type   state;
  logic [15:0] arg;
  logic [7:0]  flags;
  logic [15:0] sp;
  logic [4:0]  ridx;
  logic [1:0]  sleep_cfg;

  logic        apb_acc;
  logic        wr_ok;
  logic        idle;
  logic        start;
  logic [7:0]  rd_val;
  logic [4:0]  ptr_idx;
  logic [4:0]  ptr_hi;
  logic [15:0] ptr_val;
  logic [15:0] z_val;
  logic        is_dmem;
  logic        is_store;
  logic        is_load;
  logic        is_pm;
  logic [15:0] next_addr;
  logic [4:0]  pm_dst;
  logic [7:0]  alu_val;
  logic [7:0]  alu_flags;
  logic [31:0] rd_mux;
  logic        rd_err;

  assign apb_acc = i_psel && i_penable;
  // write lands only at the edge where pready is already high
  assign wr_ok   = apb_acc && i_pwrite && o_pready;
  assign idle    = (state == ST_IDLE);
  assign start   = wr_ok && idle && (i_paddr == `OFF_CMD);
  assign rd_val  = regs[cmd.reg_idx];
  assign z_val   = {regs[`PTR_Z + 5'h01], regs[`PTR_Z]};
  assign ptr_hi  = 5'(ptr_idx + 5'h01);
  assign ptr_val = {regs[ptr_hi], regs[ptr_idx]};
  assign pm_dst  = (cmd.op == OP_PMR_R0) ? `REG_R0 : cmd.reg_idx; // RQ14
  assign is_pm   = cmd.op inside {OP_PMR_R0, OP_PMR, OP_PMR_INC};
  assign is_store = cmd.op inside {OP_ST, OP_ST_INC, OP_ST_DEC,
                                   OP_STQ, OP_STA, OP_PUSH};
  assign is_load  = cmd.op inside {OP_LD, OP_LD_INC, OP_LD_DEC,
                                   OP_LDQ, OP_LDA, OP_POP};
  assign is_dmem  = is_store || is_load;

  always_comb begin
    case (cmd.ptr_sel)
      2'h0:    ptr_idx = `PTR_X;
      2'h1:    ptr_idx = `PTR_Y;
      default: ptr_idx = `PTR_Z;
    endcase
  end

  // --------------------------------------------------------------
  // data memory address
  // --------------------------------------------------------------
  always_comb begin
    case (cmd.op)
      OP_LD_DEC, OP_ST_DEC: next_addr = ptr_val - 16'h0001; // RQ7 RQ10
      OP_LDQ, OP_STQ:  next_addr = ptr_val + {10'h000, arg[5:0]}; // RQ8 RQ11
      OP_LDA, OP_STA:  next_addr = arg;                     // RQ12 RQ13
      OP_PUSH:         next_addr = sp;                      // RQ15
      OP_POP:          next_addr = sp + 16'h0001;           // RQ16
      default:         next_addr = ptr_val;                 // RQ6 RQ9
    endcase
  end

  flag_shift_unit u_alu (
    .i_op    (cmd.op),
    .i_val   (rd_val),
    .i_flags (flags),
    .i_sel   (cmd.bit_sel),
    .i_set   (cmd.flag_set),
    .o_val   (alu_val),
    .o_flags (alu_flags)
  );

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (start) state <= ST_EXEC;
        ST_EXEC: begin
          if (is_dmem)     state <= ST_MEM;  // RQ6
          else if (is_pm)  state <= ST_PM1;  // RQ14
          else             state <= ST_IDLE; // RQ17 RQ18
        end
        ST_MEM:  state <= ST_IDLE;
        ST_PM1:  state <= ST_PM2;
        ST_PM2:  state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd <= cmd_type'(16'h0000);
      arg <= `ARG_RST;
      ridx <= 5'h00;
      sleep_cfg <= `CTRL_RST;
    end else if (wr_ok && idle) begin
      case (i_paddr)
        `OFF_CMD:  cmd <= cmd_type'(i_pwdata[15:0]);
        `OFF_ARG:  arg <= i_pwdata[15:0];
        `OFF_RIDX: ridx <= i_pwdata[4:0];
        `OFF_CTRL: sleep_cfg <= i_pwdata[1:0];
        default:   ridx <= ridx;
      endcase
    end
  end

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  // data pointer moves at the execute edge; that same edge latches the old
  // address into the memory request, so post-increment stays exact
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      if (wr_ok && idle && i_paddr == `OFF_RDATA) begin
        regs[ridx] <= i_pwdata[7:0];
      end
      if (state == ST_EXEC) begin
        if (cmd.op inside {OP_RRC, OP_SRA, OP_T2B}) begin
          regs[cmd.reg_idx] <= alu_val;                 // RQ1 RQ2 RQ4
        end
        if (cmd.op inside {OP_LD_INC, OP_ST_INC}) begin
          {regs[ptr_hi], regs[ptr_idx]} <= ptr_val + 16'h0001; // RQ6 RQ9
        end
        if (cmd.op inside {OP_LD_DEC, OP_ST_DEC}) begin
          {regs[ptr_hi], regs[ptr_idx]} <= next_addr;   // RQ7 RQ10
        end
      end
      if (state == ST_MEM && is_load) begin
        regs[cmd.reg_idx] <= i_dmem_rdata;              // RQ12 RQ16
      end
      if (state == ST_PM2) begin
        regs[pm_dst] <= i_pmem_rdata;                   // RQ14
        if (cmd.op == OP_PMR_INC) begin
          {regs[`PTR_Z + 5'h01], regs[`PTR_Z]} <= z_val + 16'h0001; // RQ14
        end
      end
    end
  end

  // --------------------------------------------------------------
  // flags and stack pointer
  // --------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags <= `FLAGS_RST;
    end else if (state == ST_EXEC) begin
      flags <= alu_flags;                               // RQ3 RQ5
    end else if (wr_ok && idle && i_paddr == `OFF_FLAGS) begin
      flags <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sp <= `SP_RST;
    end else if (state == ST_EXEC && cmd.op == OP_PUSH) begin
      sp <= sp - 16'h0001;                              // RQ15
    end else if (state == ST_EXEC && cmd.op == OP_POP) begin
      sp <= sp + 16'h0001;                              // RQ16
    end else if (wr_ok && idle && i_paddr == `OFF_SP) begin
      sp <= i_pwdata[15:0];
    end
  end

  // --------------------------------------------------------------
  // memory ports
  // --------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dmem      <= dmem_type'(26'h0000000);
      o_pmem_addr <= 16'h0000;
    end else begin
      o_dmem.req <= (state == ST_EXEC) && is_dmem;
      o_dmem.we  <= (state == ST_EXEC) && is_store;     // RQ9 RQ13
      if (state == ST_EXEC) begin
        o_dmem.addr  <= next_addr;
        o_dmem.wdata <= rd_val;                         // RQ15
      end
      if (state == ST_EXEC && is_pm) begin
        o_pmem_addr <= z_val;                           // RQ14
      end
    end
  end

  // --------------------------------------------------------------
  // sleep and watchdog
  // --------------------------------------------------------------
  // a new command is the only wake source seen by this block
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sleep      <= 1'b0;
      o_sleep_mode <= `CTRL_RST;
      o_wdt_kick   <= 1'b0;
    end else begin
      o_wdt_kick <= (state == ST_EXEC) && (cmd.op == OP_KICK); // RQ18
      if (state == ST_EXEC && cmd.op == OP_SLEEP) begin
        o_sleep      <= 1'b1;                           // RQ17
        o_sleep_mode <= sleep_cfg;                      // RQ17
      end else if (start) begin
        o_sleep <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------
  always_comb begin
    rd_err = 1'b0;
    case (i_paddr)
      `OFF_CMD:   rd_mux = {16'h0000, cmd};
      `OFF_ARG:   rd_mux = {16'h0000, arg};
      `OFF_FLAGS: rd_mux = {24'h000000, flags};
      `OFF_SP:    rd_mux = {16'h0000, sp};
      `OFF_RIDX:  rd_mux = {27'h0000000, ridx};
      `OFF_RDATA: rd_mux = {24'h000000, regs[ridx]};
      `OFF_CTRL:  rd_mux = {30'h00000000, sleep_cfg};
      `OFF_STAT:  rd_mux = {30'h00000000, o_sleep, !idle};
      default: begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  // one wait state so that read data comes from a flop
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_acc && !o_pready;
      if (apb_acc && !o_pready) begin
        o_prdata  <= i_pwrite ? 32'h00000000 : rd_mux;
        o_pslverr <= rd_err;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  logic ex;
  assign ex = (state == ST_EXEC);

  property p_rrc;
    ex && cmd.op == OP_RRC |=> rd_val == {$past(flags[`FL_C]), $past(rd_val[7:1])}
      && flags[`FL_C] == $past(rd_val[0]) && idle;
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate result wrong"); // RQ1

  property p_sra;
    ex && cmd.op == OP_SRA |=> rd_val == {$past(rd_val[7]), $past(rd_val[7:1])}
      && flags[`FL_N] == rd_val[7];
  endproperty
  a_sra: assert property (p_sra) else $error("arith shift wrong"); // RQ2

  property p_b2t;
    ex && cmd.op == OP_B2T |=> flags[`FL_T] == $past(rd_val[cmd.bit_sel])
      && {flags[7], flags[5:0]} == $past({flags[7], flags[5:0]});
  endproperty
  a_b2t: assert property (p_b2t) else $error("bit to flag wrong"); // RQ3

  property p_t2b;
    ex && cmd.op == OP_T2B |=> rd_val[cmd.bit_sel] == $past(flags[`FL_T])
      && $stable(flags);
  endproperty
  a_t2b: assert property (p_t2b) else $error("flag to bit wrong"); // RQ4

  property p_flag;
    ex && cmd.op == OP_FLAG |=> flags[cmd.bit_sel] == cmd.flag_set
      && ((flags ^ $past(flags)) & ~(8'h01 << cmd.bit_sel)) == 8'h00;
  endproperty
  a_flag: assert property (p_flag) else $error("flag op wrong"); // RQ5

  property p_ld_inc;
    ex && cmd.op == OP_LD_INC |=> o_dmem.req && o_dmem.addr == $past(ptr_val)
      && ptr_val == $past(ptr_val) + 16'h0001 ##1 idle;
  endproperty
  a_ld_inc: assert property (p_ld_inc) else $error("post-inc read wrong"); // RQ6

  property p_st_dec;
    ex && cmd.op == OP_ST_DEC |=> o_dmem.we && o_dmem.addr == ptr_val
      && ptr_val == $past(ptr_val) - 16'h0001 ##1 idle;
  endproperty
  a_st_dec: assert property (p_st_dec) else $error("pre-dec write wrong"); // RQ10

  property p_ldq;
    ex && cmd.op == OP_LDQ |=> $stable(ptr_val)
      && o_dmem.addr == ptr_val + {10'h000, arg[5:0]} && !o_dmem.we;
  endproperty
  a_ldq: assert property (p_ldq) else $error("displaced read wrong"); // RQ8

  property p_lda;
    ex && cmd.op == OP_LDA |=> o_dmem.addr == arg ##1 idle
      && rd_val == $past(i_dmem_rdata) && $stable(flags);
  endproperty
  a_lda: assert property (p_lda) else $error("direct read wrong"); // RQ12

  property p_pmr;
    ex && is_pm |=> o_pmem_addr == $past(z_val) ##1 state == ST_PM2 ##1 idle
      && regs[pm_dst] == $past(i_pmem_rdata);
  endproperty
  a_pmr: assert property (p_pmr) else $error("program read wrong"); // RQ14

  property p_push;
    ex && cmd.op == OP_PUSH |=> o_dmem.we && o_dmem.addr == $past(sp)
      && sp == $past(sp) - 16'h0001 && o_dmem.wdata == $past(rd_val);
  endproperty
  a_push: assert property (p_push) else $error("push wrong"); // RQ15

  property p_pop;
    ex && cmd.op == OP_POP |=> sp == $past(sp) + 16'h0001 && o_dmem.addr == sp;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong"); // RQ16

  property p_sleep;
    ex && cmd.op == OP_SLEEP |=> o_sleep && idle && $stable(flags)
      && o_sleep_mode == sleep_cfg;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep wrong"); // RQ17

  property p_kick;
    ex && cmd.op == OP_KICK |=> o_wdt_kick && idle && $stable(flags) ##1 !o_wdt_kick;
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog kick wrong"); // RQ18

  c_store: cover property (ex && is_store ##1 o_dmem.we);
  c_pmr_inc: cover property (ex && cmd.op == OP_PMR_INC ##3 idle);
  c_sleep_wake: cover property (o_sleep ##[1:50] start);
  c_slverr: cover property (o_pslverr);

endmodule // exec_unit
`default_nettype wire

// *** mem_partner.sv ***
/*
  partner model: data sram with combinational read and program
  memory with one-cycle registered read.
  assumes the execution unit memory ports and a single clock.
*/
`timescale 1ns/1ns
`default_nettype none

module mem_partner (
  input  wire logic               i_mclk,
  input  wire exec_pkg::dmem_type i_dmem,
  output logic [7:0]              o_dmem_rdata,
  input  wire logic [15:0]        i_pmem_addr,
  output logic [7:0]              o_pmem_rdata
);
  import exec_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // only 256 bytes: upper address bits alias
  logic [7:0] mem [0:255];
  logic [7:0] idle_pat;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    idle_pat = 8'h55;
  end

  always @(posedge i_mclk) begin
    idle_pat <= ~idle_pat;
    if (i_dmem.req && i_dmem.we) begin
      mem[i_dmem.addr[7:0]] <= i_dmem.wdata;
    end
    o_pmem_rdata <= i_pmem_addr[7:0] ^ i_pmem_addr[15:8] ^ 8'h96;
  end

  // idle bus shows a toggling pattern, never a stale byte
  assign o_dmem_rdata = i_dmem.req ? mem[i_dmem.addr[7:0]] : idle_pat;
endmodule // mem_partner

`default_nettype wire

// *** bit_flag_and_transfer_exec_tb.sv ***
/*
  self-checking bench for exec_unit: apb master tasks, one task
  per scenario.
  assumes exec_pkg, exec_defs.svh and mem_partner.
*/
`timescale 1ns/1ns
`include "exec_defs.svh"
`default_nettype none

module bit_flag_and_transfer_exec_tb;
  import exec_pkg::*;

  logic        mclk, rstn, psel, penable, pwrite;
  logic [7:0]  paddr, dmem_rdata, pmem_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, last_err, sleep, wdt_kick;
  logic [15:0] pmem_addr;
  logic [1:0]  sleep_mode;
  dmem_type    dmem;
  int          num_errors, cmp_count, kick_cnt, req_cnt;

  exec_unit uut (.i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_dmem(dmem), .i_dmem_rdata(dmem_rdata),
    .o_pmem_addr(pmem_addr), .i_pmem_rdata(pmem_rdata), .o_sleep(sleep),
    .o_sleep_mode(sleep_mode), .o_wdt_kick(wdt_kick));

  mem_partner mdl (.i_mclk(mclk), .i_dmem(dmem), .o_dmem_rdata(dmem_rdata),
    .i_pmem_addr(pmem_addr), .o_pmem_rdata(pmem_rdata));

  // ------------------------------------------------------------
  // clock and pulse counters
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (wdt_kick === 1'b1) kick_cnt++;
    if (dmem.req === 1'b1) req_cnt++;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // idle cycle after each transfer keeps one assignment per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk("pready", 1, 0);
      complete_run();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic setreg(input logic [4:0] i, input logic [7:0] v);
    wr(`OFF_RIDX, {27'h0, i});
    wr(`OFF_RDATA, {24'h0, v});
  endtask

  task automatic chkreg(input string nm, input logic [4:0] i, input logic [7:0] e);
    wr(`OFF_RIDX, {27'h0, i});
    apb(1'b0, `OFF_RDATA, 32'h0);
    chk(nm, {24'h0, e}, rd);
  endtask

  task automatic chkflags(input logic [7:0] e);
    apb(1'b0, `OFF_FLAGS, 32'h0);
    chk("flags", {24'h0, e}, rd);
  endtask

  task automatic run(input op_type o, input logic [4:0] r, input logic [1:0] p,
                     input logic [2:0] b, input logic s);
    cmd_type c;
    int      n;
    c = '{flag_set: s, bit_sel: b, ptr_sel: p, reg_idx: r, op: o};
    wr(`OFF_CMD, {16'h0, c});
    for (n = 0; n < 20; n++) begin
      apb(1'b0, `OFF_STAT, 32'h0);
      if (rd[`STAT_BUSY] === 1'b0) break;
    end
    if (n == 20) begin
      chk("busy", 0, 1);
      complete_run();
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chkflags(`FLAGS_RST);
    apb(1'b0, `OFF_SP, 32'h0);
    chk("sp", {16'h0, `SP_RST}, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 1, last_err);
    chk("unmapped", 0, rd);
  endtask

  task automatic t_shift;
    setreg(5, 8'h02);
    wr(`OFF_FLAGS, 32'h01);
    run(OP_RRC, 5, 0, 0, 0);
    chkreg("rrc", 5, 8'h81);
    chkflags(8'h0C);
    setreg(6, 8'h81);
    wr(`OFF_FLAGS, 32'h6A);
    run(OP_SRA, 6, 0, 0, 0);
    chkreg("sra", 6, 8'hC0);
    chkflags(8'h65);
  endtask

  task automatic t_bits;
    wr(`OFF_FLAGS, 32'h00);
    setreg(3, 8'h10);
    run(OP_B2T, 3, 0, 4, 0);
    chkflags(8'h40);
    setreg(4, 8'h81);
    run(OP_T2B, 4, 0, 2, 0);
    chkreg("t2b", 4, 8'h85);
    chkflags(8'h40);
  endtask

  task automatic t_flags;
    logic [7:0] e;
    e = 8'h00;
    wr(`OFF_FLAGS, 32'h00);
    for (int b = 0; b < 8; b++) begin
      run(OP_FLAG, 0, 0, 3'(b), 1'b1);
      e[b] = 1'b1;
      chkflags(e);
    end
    for (int b = 0; b < 8; b++) begin
      run(OP_FLAG, 0, 0, 3'(b), 1'b0);
      e[b] = 1'b0;
      chkflags(e);
    end
  endtask

  // pointer crosses the 0x0100 byte boundary both ways
  task automatic t_mem;
    int r0;
    r0 = req_cnt;
    wr(`OFF_FLAGS, 32'h21);
    setreg(26, 8'h00);
    setreg(27, 8'h01);
    setreg(1, 8'h5A);
    run(OP_ST_DEC, 1, 0, 0, 0);
    chk("st_dec", 8'h5A, mdl.mem[8'hFF]);
    chkreg("xl", 26, 8'hFF);
    chkreg("xh", 27, 8'h00);
    run(OP_LD_INC, 2, 0, 0, 0);
    chkreg("ld_inc", 2, 8'h5A);
    chkreg("xh", 27, 8'h01);
    run(OP_LD_DEC, 8, 0, 0, 0);
    chkreg("ld_dec", 8, 8'h5A);
    chkreg("xl", 26, 8'hFF);
    run(OP_ST_INC, 3, 0, 0, 0);
    chk("st_inc", 8'h10, mdl.mem[8'hFF]);
    chkreg("xh", 27, 8'h01);
    setreg(28, 8'h50);
    setreg(29, 8'h00);
    run(OP_ST, 1, 1, 0, 0);
    run(OP_LD, 9, 1, 0, 0);
    chkreg("ld", 9, 8'h5A);
    wr(`OFF_ARG, 32'h3);
    run(OP_STQ, 3, 1, 0, 0);
    chk("stq", 8'h10, mdl.mem[8'h53]);
    run(OP_LDQ, 10, 1, 0, 0);
    chkreg("ldq", 10, 8'h10);
    chkreg("yl", 28, 8'h50);
    wr(`OFF_ARG, 32'h70);
    run(OP_STA, 1, 0, 0, 0);
    chk("sta", 8'h5A, mdl.mem[8'h70]);
    run(OP_LDA, 11, 0, 0, 0);
    chkreg("lda", 11, 8'h5A);
    chk("req_cycles", 10, req_cnt - r0);
    chkflags(8'h21);
  endtask

  task automatic t_pm;
    setreg(30, 8'h34);
    setreg(31, 8'h12);
    run(OP_PMR_R0, 7, 0, 0, 0);
    chkreg("pmr_r0", 0, 8'h34 ^ 8'h12 ^ 8'h96);
    run(OP_PMR, 7, 0, 0, 0);
    chkreg("pmr", 7, 8'h34 ^ 8'h12 ^ 8'h96);
    chkreg("zl", 30, 8'h34);
    run(OP_PMR_INC, 12, 0, 0, 0);
    chkreg("pmr_inc", 12, 8'h34 ^ 8'h12 ^ 8'h96);
    chkreg("zl", 30, 8'h35);
    run(OP_LD_INC, 15, 2, 0, 0);
    chkreg("ld_z", 15, 8'h35 ^ 8'h3C);
    chkreg("zl", 30, 8'h36);
  endtask

  task automatic t_stack;
    setreg(13, 8'hE7);
    run(OP_PUSH, 13, 0, 0, 0);
    chk("push", 8'hE7, mdl.mem[8'hFF]);
    apb(1'b0, `OFF_SP, 32'h0);
    chk("sp", 32'hFE, rd);
    run(OP_POP, 14, 0, 0, 0);
    chkreg("pop", 14, 8'hE7);
    apb(1'b0, `OFF_SP, 32'h0);
    chk("sp", 32'hFF, rd);
    chkflags(8'h21);
  endtask

  task automatic t_mcu;
    int k0;
    wr(`OFF_CTRL, 32'h2);
    k0 = kick_cnt;
    run(OP_SLEEP, 0, 0, 0, 0);
    chk("sleep", 1, sleep);
    chk("mode", 2, sleep_mode);
    chk("sleeping", 1, rd[`STAT_SLEEP]);
    run(OP_KICK, 0, 0, 0, 0);
    chk("kick", 1, kick_cnt - k0);
    chk("wake", 0, sleep);
    chkflags(8'h21);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    cmp_count = 0;
    kick_cnt = 0;
    req_cnt = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_shift();
    t_bits();
    t_flags();
    t_mem();
    t_pm();
    t_stack();
    t_mcu();
    complete_run();
  end
endmodule // bit_flag_and_transfer_exec_tb

`default_nettype wire
